// ---- src/hlc_ctrl_bits.sv ----
//Function
// - Stopped link read: ones or abort
// - No-abort bit resets to one
// - Serial enable bit writable, no effect
// - Link clock gate-off disables PHY autogating
// - Bus clock gate-off disables PCI autogating
// - Keep-clock bit writable, no effect
// - Any reset source restores defaults
// - Enhancements honoured only when gate set
// - Enhancement register F4h, reset 4000h
// - Loadable by software or EEPROM preload
// - Bits 31..16 read zero
`timescale 1ns/1ps
`default_nettype none
`include "hlc_defs.svh"
module hlc_ctrl_bits (
	// Clock and resets.
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              global_reset_n,
	input  wire logic              por_n,
	// Configuration access.
	input  wire logic              cfg_wr,
	input  wire logic              cfg_rd,
	input  wire logic [7:0]        cfg_addr,
	input  wire logic [3:0]        cfg_be,
	input  wire logic [31:0]       cfg_wdata,
	output logic [31:0]            cfg_rdata,
	output logic                   cfg_rvalid,
	// Link register read path.
	input  wire logic              link_rd,
	input  wire logic [31:0]       link_rdata,
	input  wire logic              link_clock_stopped,
	output logic [31:0]            link_resp_data,
	output hlc_pkg::hlc_resp_t     link_resp,
	output logic                   link_resp_valid,
	// EEPROM preload.
	input  wire logic              eeprom_load,
	input  wire logic [15:0]       eeprom_data,
	// Host controller enable.
	input  wire logic              phy_enhance_gate,
	// Controls to the core.
	output logic                   link_autogate_en,
	output logic                   bus_autogate_en,
	output logic [15:0]            enh_effective
);
	import hlc_pkg::*;

	logic                   any_rstn;
	logic                   rst_n;
	logic [4:0]             misc_reg,  misc_next;
	logic [15:0]            enh_reg,   enh_next;
	logic [31:0]            rdata_reg, rdata_next;
	logic                   rvalid_reg, rvalid_next;
	logic [31:0]            lresp_data_reg, lresp_data_next;
	hlc_resp_t              lresp_reg, lresp_next;
	logic                   lvalid_reg, lvalid_next;
	logic                   lgate_reg, lgate_next;
	logic                   bgate_reg, bgate_next;
	logic [15:0]            eff_reg, eff_next;

	// Any of the three reset sources returns the bank to its reset values.
	assign any_rstn = rstn & global_reset_n & por_n;

	hlc_rst_sync u_rst (
		.clock      (clock),
		.rstn       (any_rstn),
		.rst_sync_n (rst_n)
	);

	always_comb begin
		misc_next = misc_reg;
		enh_next  = enh_reg;
		if (cfg_wr && cfg_be[0] && cfg_addr == `HLC_MISC_OFFSET) begin
			// Serial and keep-clock bits are stored only; nothing but the configuration read uses them.
			misc_next = cfg_wdata[4:0];
		end
		if (cfg_wr && cfg_addr == `HLC_ENH_OFFSET) begin
			if (cfg_be[0]) begin
				enh_next[7:0] = cfg_wdata[7:0];
			end
			if (cfg_be[1]) begin
				enh_next[15:8] = cfg_wdata[15:8];
			end
		end
		// Preload wins over a same-cycle software write, as it runs at power-up.
		if (eeprom_load) begin
			enh_next = eeprom_data;
		end
	end

	always_comb begin
		rvalid_next = cfg_rd;
		rdata_next  = 32'h0;
		if (cfg_rd) begin
			case (cfg_addr)
				`HLC_MISC_OFFSET: rdata_next = {27'h0, misc_reg};
				`HLC_ENH_OFFSET:  rdata_next = {16'h0, enh_reg};
				default:          rdata_next = 32'h0;
			endcase
		end
	end

	always_comb begin
		lvalid_next     = link_rd;
		lresp_data_next = link_rdata;
		lresp_next      = HLC_RESP_DATA;
		if (link_rd && link_clock_stopped) begin
			if (misc_reg[`HLC_NO_ABORT_BIT]) begin
				lresp_data_next = `HLC_ALL_ONES;
			end else begin
				lresp_data_next = 32'h0;
				lresp_next      = HLC_RESP_ABORT;
			end
		end
	end

	always_comb begin
		lgate_next = !misc_reg[`HLC_LINK_GATE_BIT];
		bgate_next = !misc_reg[`HLC_BUS_GATE_BIT];
		eff_next   = phy_enhance_gate ? enh_reg : 16'h0;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			misc_reg       <= `HLC_MISC_RESET;
			enh_reg        <= `HLC_ENH_RESET;
			rdata_reg      <= 32'h0;
			rvalid_reg     <= 1'b0;
			lresp_data_reg <= 32'h0;
			lresp_reg      <= HLC_RESP_DATA;
			lvalid_reg     <= 1'b0;
			lgate_reg      <= 1'b1;
			bgate_reg      <= 1'b1;
			eff_reg        <= 16'h0;
		end else begin
			misc_reg       <= misc_next;
			enh_reg        <= enh_next;
			rdata_reg      <= rdata_next;
			rvalid_reg     <= rvalid_next;
			lresp_data_reg <= lresp_data_next;
			lresp_reg      <= lresp_next;
			lvalid_reg     <= lvalid_next;
			lgate_reg      <= lgate_next;
			bgate_reg      <= bgate_next;
			eff_reg        <= eff_next;
		end
	end

	assign cfg_rdata        = rdata_reg;
	assign cfg_rvalid       = rvalid_reg;
	assign link_resp_data   = lresp_data_reg;
	assign link_resp        = lresp_reg;
	assign link_resp_valid  = lvalid_reg;
	assign link_autogate_en = lgate_reg;
	assign bus_autogate_en  = bgate_reg;
	assign enh_effective    = eff_reg;

	// The stopped-read cases are split by the no-abort bit so each property names its case.
	sequence s_stopped_read;
		link_rd && link_clock_stopped;
	endsequence

	sequence s_quiet_stopped_read;
		link_rd && link_clock_stopped && misc_reg[`HLC_NO_ABORT_BIT];
	endsequence

	sequence s_loud_stopped_read;
		link_rd && link_clock_stopped && !misc_reg[`HLC_NO_ABORT_BIT];
	endsequence

	chk_ones_when_noabort: assert property (@(posedge clock) disable iff (!rst_n)
		s_quiet_stopped_read |=> link_resp_valid && link_resp_data == `HLC_ALL_ONES
		&& link_resp == HLC_RESP_DATA)
		else $error("stopped read did not return all ones");
	chk_abort_when_clear: assert property (@(posedge clock) disable iff (!rst_n)
		s_loud_stopped_read |=> link_resp == HLC_RESP_ABORT)
		else $error("stopped read did not abort");
	chk_reset_values: assert property (@(posedge clock)
		$rose(rst_n) |-> misc_reg == 5'h10 && enh_reg == 16'h4000)
		else $error("reset values wrong");
	chk_link_gate: assert property (@(posedge clock) disable iff (!rst_n)
		##1 link_autogate_en == !$past(misc_reg[2]))
		else $error("link autogate does not follow bit");
	chk_bus_gate: assert property (@(posedge clock) disable iff (!rst_n)
		##1 bus_autogate_en == !$past(misc_reg[1]))
		else $error("bus autogate does not follow bit");
	chk_enh_gated: assert property (@(posedge clock) disable iff (!rst_n)
		!phy_enhance_gate |=> enh_effective == 16'h0)
		else $error("enhancement honoured without gate");
	chk_eeprom_load: assert property (@(posedge clock) disable iff (!rst_n)
		eeprom_load |=> enh_reg == $past(eeprom_data))
		else $error("preload not taken");
	chk_upper_zero: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_rd && cfg_addr == 8'hf4 |=> cfg_rdata[31:16] == 16'h0 && cfg_rvalid)
		else $error("reserved bits not zero");
	chk_misc_write: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_wr && cfg_be[0] && cfg_addr == 8'hf0 |=> misc_reg == $past(cfg_wdata[4:0]))
		else $error("misc write not stored");
	chk_stopped_valid: assert property (@(posedge clock) disable iff (!rst_n)
		s_stopped_read |=> link_resp_valid)
		else $error("stopped read gave no answer");
	chk_running_read: assert property (@(posedge clock) disable iff (!rst_n)
		link_rd && !link_clock_stopped |=> link_resp_valid && link_resp == HLC_RESP_DATA
		&& link_resp_data == $past(link_rdata))
		else $error("running read did not pass link data");
	chk_link_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		!link_rd |=> !link_resp_valid)
		else $error("link answer without a read");
	chk_enh_follows: assert property (@(posedge clock) disable iff (!rst_n)
		phy_enhance_gate |=> enh_effective == $past(enh_reg))
		else $error("enhancement not honoured with gate");
	chk_enh_write: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_wr && cfg_addr == `HLC_ENH_OFFSET && cfg_be[1:0] == 2'h3 && !eeprom_load
		|=> enh_reg == $past(cfg_wdata[15:0]))
		else $error("enhancement write not stored");
	chk_enh_read: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_rd && cfg_addr == `HLC_ENH_OFFSET |=> cfg_rdata[15:0] == $past(enh_reg))
		else $error("enhancement read wrong");
	chk_misc_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!(cfg_wr && cfg_be[0] && cfg_addr == `HLC_MISC_OFFSET) |=> $stable(misc_reg))
		else $error("misc bits changed without a write");
	chk_cfg_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		!cfg_rd |=> !cfg_rvalid)
		else $error("read answer without a read");
endmodule
`default_nettype wire

// ---- src/hlc_defs.svh ----
`ifndef HLC_DEFS_SVH
`define HLC_DEFS_SVH

// Configuration-space byte offsets.
`define HLC_MISC_OFFSET     8'hf0
`define HLC_ENH_OFFSET      8'hf4

// Miscellaneous control bit positions.
`define HLC_NO_ABORT_BIT    4
`define HLC_SERIAL_BIT      3
`define HLC_LINK_GATE_BIT   2
`define HLC_BUS_GATE_BIT    1
`define HLC_KEEP_CLK_BIT    0

// Reset values and the all-ones stopped-read data word.
`define HLC_MISC_RESET      5'h10
`define HLC_ENH_RESET       16'h4000
`define HLC_ALL_ONES        32'hffffffff

`endif

// ---- src/hlc_pkg.sv ----
`default_nettype none
package hlc_pkg;
	typedef enum logic [1:0] {
		HLC_RESP_DATA  = 2'h1,
		HLC_RESP_ABORT = 2'h2
	} hlc_resp_t;
endpackage
`default_nettype wire

// ---- src/hlc_rst_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module hlc_rst_sync (
	// Clock and raw reset.
	input  wire logic clock,
	input  wire logic rstn,
	// Released reset.
	output logic      rst_sync_n
);
	logic stage_reg;
	logic out_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stage_reg <= 1'b0;
			out_reg   <= 1'b0;
		end else begin
			stage_reg <= 1'b1;
			out_reg   <= stage_reg;
		end
	end

	assign rst_sync_n = out_reg;
endmodule
`default_nettype wire

// ---- tb/hlc_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hlc_link_model (
	// Clock and link state.
	input  wire logic        clock,
	input  wire logic        stopped,
	// Data toward the controller.
	output logic [31:0]      rdata
);
	initial rdata = 32'h0;
	// A stopped domain holds nothing valid, so the lines toggle every cycle.
	always @(posedge clock) begin
		rdata <= stopped ? ~rdata : 32'h5a5a0f0f;
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                clock = 0, rstn = 0, grn = 1, porn = 1, wr = 0, rd = 0;
	logic                lrd = 0, stop = 0, eld = 0, gate = 0, rv, lv, lag, bag;
	logic [7:0]          addr = 8'h0;
	logic [3:0]          be = 4'h0;
	logic [31:0]         wd = 32'h0, ld, rdat, lrdat;
	logic [15:0]         ed = 16'h0, eff;
	hlc_pkg::hlc_resp_t  lresp;
	int                  bad_count = 0, checked = 0, cyc = 0;

	always #25 clock = ~clock;

	hlc_link_model u_hlc_link_model (.clock(clock), .stopped(stop), .rdata(ld));
	hlc_ctrl_bits u_hlc_ctrl_bits (.clock(clock), .rstn(rstn), .global_reset_n(grn),
		.por_n(porn), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be),
		.cfg_wdata(wd), .cfg_rdata(rdat), .cfg_rvalid(rv), .link_rd(lrd),
		.link_rdata(ld), .link_clock_stopped(stop), .link_resp_data(lrdat),
		.link_resp(lresp), .link_resp_valid(lv), .eeprom_load(eld), .eeprom_data(ed),
		.phy_enhance_gate(gate), .link_autogate_en(lag), .bus_autogate_en(bag),
		.enh_effective(eff));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task complete_run();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 1000) begin
			bad_count++;
			complete_run();
		end
	end

	task cw(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clock);
		{wr, addr, be, wd} = {1'b1, a, b, d};
		@(negedge clock);
		wr = 0;
	endtask

	task cr(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clock);
		{rd, addr} = {1'b1, a};
		@(negedge clock);
		rd = 0;
		chk({31'h0, rv}, 32'h1);
		chk(rdat, exp);
	endtask

	task lr(input logic s, input logic [31:0] exp, input logic [1:0] code);
		// The model needs one edge in the new state before its data is meaningful.
		@(negedge clock);
		stop = s;
		@(negedge clock);
		lrd = 1;
		@(negedge clock);
		lrd = 0;
		chk({31'h0, lv}, 32'h1);
		chk({30'h0, lresp}, {30'h0, code});
		chk(lrdat, exp);
	endtask

	// Source k of rstn, global and power-on reset is pulled low for two cycles.
	task rs(input int k);
		@(negedge clock);
		{rstn, grn, porn} = 3'b111 & ~(3'b100 >> k);
		gate = 0;
		repeat (2) @(negedge clock);
		{rstn, grn, porn} = 3'b111;
		repeat (4) @(negedge clock);
	endtask

	initial begin
		for (int k = 0; k < 3; k++) begin
			rs(k);
			cr(8'hf0, 32'h10);
			cr(8'hf4, 32'h4000);
			chk({30'h0, lag, bag}, 32'h3);
			lr(0, 32'h5a5a0f0f, 2'h1);
			lr(1, 32'hffffffff, 2'h1);
			cw(8'hf0, 4'he, 32'h1f);
			cr(8'hf0, 32'h10);
			cw(8'hf0, 4'h1, 32'hffffffef);
			cr(8'hf0, 32'hf);
			chk({30'h0, lag, bag}, 32'h0);
			lr(1, 32'h0, 2'h2);
			cw(8'hf0, 4'h1, 32'h14);
			cr(8'hf0, 32'h14);
			chk({30'h0, lag, bag}, 32'h1);
			cw(8'hf8, 4'hf, 32'hffffffff);
			cr(8'hf8, 32'h0);
			cw(8'hf4, 4'hf, 32'hffffffff);
			cr(8'hf4, 32'hffff);
			chk({16'h0, eff}, 32'h0);
			gate = 1;
			@(negedge clock);
			chk({16'h0, eff}, 32'hffff);
			{eld, ed} = {1'b1, 16'h1234};
			@(negedge clock);
			eld = 0;
			cr(8'hf4, 32'h1234);
			chk({16'h0, eff}, 32'h1234);
		end
		complete_run();
	end
endmodule
`default_nettype wire
